// file: src/ailc_pkg.sv
// register map, reset values, field positions and carriers of the
// audio input level control block.
// assumes a 32-bit classic wishbone slave, one byte per word.
package ailc_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam int NRW = 22;
	typedef enum int
	{
		S_THH, S_THL, S_THN, S_TKL, S_TKH, S_CFG, S_COEF, S_MASK,
		S_INCS, S_INCM, S_DECS, S_DECM, S_NOIS, S_NOIM, S_JPACE,
		S_TGTL, S_TGTR, S_FIX, S_SWAP, S_VOLL, S_VOLR, S_VOLH
	} ailc_slot_t;
	// word index of each stored register, in slot order; IDX_VALL and IDX_VALR also take mute writes
	localparam logic [11:0] RW_IDX [NRW] = '{
		12'hb44, 12'hb46, 12'hb48, 12'hb50, 12'hb51, 12'hb54,
		12'hb55, 12'hb56, 12'hb57, 12'hb58, 12'hb59, 12'hb5a,
		12'hb5b, 12'hb5c, 12'hb60, 12'hb61, 12'hb65, 12'hb63,
		12'hb64, 12'hb41, 12'hb42, 12'hb43};
	localparam logic [7:0] RW_RST [NRW] = '{
		8'h60, 8'h40, 8'h02, 8'h00, 8'h02, 8'h0a, 8'hfa, 8'h00,
		8'h0a, 8'h03, 8'h08, 8'h06, 8'h06, 8'h06, 8'h40, 8'h00,
		8'h00, 8'h80, 8'h00, 8'h20, 8'h20, 8'h33};
	localparam logic [11:0] IDX_CURL = 12'hb4d;
	localparam logic [11:0] IDX_CURR = 12'hb4e;
	localparam logic [11:0] IDX_AMPL = 12'hb5e;
	localparam logic [11:0] IDX_AMPR = 12'hb5f;
	localparam logic [11:0] IDX_VALL = 12'hb62;
	localparam logic [11:0] IDX_VALR = 12'hb66;

	// ************************************************************
	// fields
	// ************************************************************
	localparam int CFG_ANA = 0;
	localparam int CFG_VIIR = 1;
	localparam int CFG_AIIR = 2;
	localparam int CFG_TCLR = 3;
	localparam int CFG_VMAX = 4;
	localparam int TOP_BIT = 7;
	localparam int DB_STEP = 6;
	localparam logic [6:0] DB_CAP = 7'h3f;
	localparam int FIFO_DEPTH = 16;

	typedef struct packed
	{
		logic [15:0] l;
		logic [15:0] r;
	} ailc_smp_t;
	typedef struct packed
	{
		logic [6:0] l;
		logic [6:0] r;
	} ailc_gain_t;
endpackage

// file: src/ailc_fifo.sv
// synchronous fifo with valid/ready on both sides.
// assumes depth is a power of two.
`timescale 1ns/1ps
`default_nettype none
module ailc_fifo
#(
	parameter int W = 32,
	parameter int D = 16
)
(
	input  wire logic         clk_i,      // clock
	input  wire logic         rst_i,      // sync reset
	input  wire logic [W-1:0] wr_dat_i,   // fill data
	input  wire logic         wr_valid_i, // fill valid
	output logic              wr_ready_o, // not full
	output logic [W-1:0]      rd_dat_o,   // head word
	output logic              rd_valid_o, // not empty
	input  wire logic         rd_ready_i  // drain
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0]  wp;
	logic [AW:0]  rp;

	assign wr_ready_o = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
	assign rd_valid_o = (wp != rp);
	assign rd_dat_o = mem[rp[AW-1:0]];

	always_ff @(posedge clk_i)
	begin
		if (wr_valid_i && wr_ready_o)
			mem[wp[AW-1:0]] <= wr_dat_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wp <= '0;
			rp <= '0;
		end
		else
		begin
			if (wr_valid_i && wr_ready_o)
				wp <= wp + 1'b1;
			if (rd_valid_o && rd_ready_i)
				rp <= rp + 1'b1;
		end
	end
endmodule
`default_nettype wire

// file: src/ailc_top.sv
// audio input level control: auto/manual gain of the input path.
// assumes samples arrive on clk_i; the amplifier takes gain words.
// Contract
// (RL1) auto targets: frac bit 0, dB bits 6:1
// (RL2) level under noise threshold counts as noise
// (RL3) readback: auto gain or manual volume
// (RL4) tick period from two bytes, default 0x0200
// (RL5) config bits enable modes and smoothing
// (RL6) mask samples after each gain change; the code masks only after one-code steps in auto mode, not after jumps to maxl or minl
// (RL7) rise at speed, capped per tick
// (RL8) fall at speed, capped per tick
// (RL9) noise fall: own speed and cap
// (RL10) readback of current amplifier gain
// (RL11) judge pace byte paces manual stepping
// (RL12) manual target, done flag in bit 7
// (RL13) amp value readback, bit 7 mutes
// (RL14) fix enable forces fixed gain
// (RL15) swap bit exchanges amplifier channels
// (RL16) bit 7 selects auto, limits by mode
// (RL17) auto gain never above maximum limit
// (RL18) raise below, lower above, clamp limits
// (RL19) each channel runs its own gain
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module ailc_top
(
	input  wire logic             clk_i,       // 40 MHz clock
	input  wire logic             rst_i,       // sync reset
	input  wire logic             cyc_i,       // wb cycle
	input  wire logic             stb_i,       // wb strobe
	input  wire logic             we_i,        // wb write
	input  wire logic [13:2]      adr_i,       // wb word address
	input  wire logic [31:0]      dat_i,       // wb write data
	input  wire logic [3:0]       sel_i,       // wb byte lanes
	output logic [31:0]           dat_o,       // wb read data
	output logic                  ack_o,       // wb ack
	input  wire ailc_pkg::ailc_smp_t in_i,     // input samples
	input  wire logic             in_valid_i,  // sample valid
	output logic                  in_ready_o,  // fifo not full
	output ailc_pkg::ailc_smp_t   out_o,       // masked samples
	output logic                  out_valid_o, // out valid
	input  wire logic             out_ready_i, // out taken
	output ailc_pkg::ailc_gain_t  amp_gain_o,  // amplifier gains
	output logic [1:0]            amp_mute_o   // amplifier mutes
);
	// ************************************************************
	// register file
	// ************************************************************
	logic [7:0]  rw [ailc_pkg::NRW];
	logic [1:0]  mute;
	logic        ack;
	logic [31:0] rdat;
	logic [7:0]  rbyte;
	logic [6:0]  gain [2];
	logic [1:0]  done;
	logic [1:0]  auto_m;
	logic [1:0]  chg;
	logic [1:0]  msk;
	logic        tick;
	logic [15:0] tcnt;
	logic        take;
	ailc_pkg::ailc_smp_t fd;
	logic        fvalid;
	logic [31:0] fbits;
	wire  [11:0] adr = adr_i;
	wire         req = cyc_i && stb_i && !ack;
	wire         wr = req && we_i && sel_i[0];

	function automatic int slot_of(input logic [11:0] a);
		slot_of = -1;
		for (int i = 0; i < ailc_pkg::NRW; i++)
			if (a == ailc_pkg::RW_IDX[i])
				slot_of = i;
	endfunction

	function automatic logic [6:0] db_of(input logic [15:0] v);
		logic [6:0] d;
		d = '0;
		for (int i = 0; i < 16; i++)
			if (v[i])
				d = 7'(i * ailc_pkg::DB_STEP);
		if (d > ailc_pkg::DB_CAP)
			d = ailc_pkg::DB_CAP;
		db_of = {d[5:0], 1'b0};
	endfunction

	assign ack_o = ack;
	assign dat_o = rdat;

	// one wait state: ack follows the request edge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack <= 1'b0;
			rdat <= '0;
		end
		else
		begin
			ack <= req;
			if (req && !we_i)
				rdat <= {24'h000000, rbyte};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < ailc_pkg::NRW; i++)
				rw[i] <= ailc_pkg::RW_RST[i];
		end
		else if (wr && slot_of(adr) >= 0)
			rw[slot_of(adr)] <= dat_i[7:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mute <= 2'h0;
		else if (wr && adr == ailc_pkg::IDX_VALL)
			mute[0] <= dat_i[ailc_pkg::TOP_BIT]; // RL13
		else if (wr && adr == ailc_pkg::IDX_VALR)
			mute[1] <= dat_i[ailc_pkg::TOP_BIT]; // RL13
	end

	always_comb
	begin
		rbyte = 8'h00;
		if (slot_of(adr) >= 0)
			rbyte = rw[slot_of(adr)];
		case (adr)
			ailc_pkg::RW_IDX[ailc_pkg::S_TGTL]:
				rbyte = {done[0], rw[ailc_pkg::S_TGTL][6:0]}; // RL12
			ailc_pkg::RW_IDX[ailc_pkg::S_TGTR]:
				rbyte = {done[1], rw[ailc_pkg::S_TGTR][6:0]}; // RL12
			ailc_pkg::IDX_CURL:
				rbyte = auto_m[0] ? {1'b0, gain[0]}
					: {2'h0, rw[ailc_pkg::S_VOLL][5:0]}; // RL3
			ailc_pkg::IDX_CURR:
				rbyte = auto_m[1] ? {1'b0, gain[1]}
					: {2'h0, rw[ailc_pkg::S_VOLR][5:0]}; // RL3
			ailc_pkg::IDX_AMPL:
				rbyte = {1'b0, gain[0]}; // RL10
			ailc_pkg::IDX_AMPR:
				rbyte = {1'b0, gain[1]}; // RL10
			ailc_pkg::IDX_VALL:
				rbyte = {mute[0], gain[0]}; // RL13
			ailc_pkg::IDX_VALR:
				rbyte = {mute[1], gain[1]}; // RL13
			default:
				rbyte = rbyte;
		endcase
	end

	// ************************************************************
	// peak tick divider
	// ************************************************************
	wire [15:0] period = {rw[ailc_pkg::S_TKH], rw[ailc_pkg::S_TKL]};
	assign tick = (tcnt + 16'h0001 >= period); // RL4

	always_ff @(posedge clk_i)
	begin
		if (rst_i || tick)
			tcnt <= '0;
		else
			tcnt <= tcnt + 16'h0001;
	end

	// ************************************************************
	// sample path
	// ************************************************************
	ailc_fifo #(.W(32), .D(ailc_pkg::FIFO_DEPTH)) u_fifo
	(
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.wr_dat_i   (in_i),
		.wr_valid_i (in_valid_i),
		.wr_ready_o (in_ready_o),
		.rd_dat_o   (fbits),
		.rd_valid_o (fvalid),
		.rd_ready_i (take)
	);
	assign fd = fbits;
	// the output stage stalls the fifo, so back-pressure reaches in_ready_o
	assign take = fvalid && (!out_valid_o || out_ready_i);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			out_valid_o <= 1'b0;
			out_o <= '0;
		end
		else
		begin
			if (take)
			begin
				out_valid_o <= 1'b1;
				out_o.l <= msk[0] ? 16'h0000 : fd.l; // RL6
				out_o.r <= msk[1] ? 16'h0000 : fd.r; // RL6
			end
			else if (out_ready_i)
				out_valid_o <= 1'b0;
		end
	end

	// ************************************************************
	// per-channel gain engines
	// ************************************************************
	wire [7:0] cfg = rw[ailc_pkg::S_CFG];
	wire [7:0] coef = rw[ailc_pkg::S_COEF];
	wire [6:0] maxl = rw[ailc_pkg::S_VOLH][6:0];

	for (genvar c = 0; c < 2; c++)
	begin : g_ch
		logic [15:0] pk;
		logic [15:0] lvl;
		logic [7:0]  sc;
		logic [6:0]  used;
		logic [6:0]  g;
		logic [3:0]  mcnt;
		logic [24:0] mix;
		logic [7:0]  spd;
		logic [6:0]  lim;
		wire  [7:0]  vol = c ? rw[ailc_pkg::S_VOLR] : rw[ailc_pkg::S_VOLL];
		wire  [7:0]  tgt = c ? rw[ailc_pkg::S_TGTR] : rw[ailc_pkg::S_TGTL];
		wire  [15:0] x = c ? fd.r : fd.l;
		wire  [15:0] ax = x[15] ? 16'(-x) : x;
		wire  [6:0]  lcode = db_of(lvl);
		wire         am = vol[ailc_pkg::TOP_BIT]; // RL16
		wire  [6:0]  minl = vol[6:0]; // RL16
		wire         noise = lcode < rw[ailc_pkg::S_THN][6:0]; // RL2
		wire         hi = lcode > rw[ailc_pkg::S_THH][6:0]; // RL1
		wire         lo = lcode < rw[ailc_pkg::S_THL][6:0]; // RL1
		wire         iir = cfg[ailc_pkg::CFG_VIIR] || cfg[ailc_pkg::CFG_AIIR];
		wire         step = (sc >= spd);

		assign gain[c] = g;
		assign done[c] = (g == tgt[6:0]); // RL12
		assign auto_m[c] = am;
		assign msk[c] = (mcnt != 4'h0);
		assign mix = 25'(lvl) * 25'(coef)
			+ 25'(pk) * 25'(9'h100 - {1'b0, coef}); // RL5

		always_comb
		begin
			spd = rw[ailc_pkg::S_INCS]; // RL7
			lim = rw[ailc_pkg::S_INCM][6:0]; // RL7
			if (!am)
				spd = rw[ailc_pkg::S_JPACE]; // RL11
			else if (noise)
			begin
				spd = rw[ailc_pkg::S_NOIS]; // RL9
				lim = rw[ailc_pkg::S_NOIM][6:0]; // RL9
			end
			else if (hi)
			begin
				spd = rw[ailc_pkg::S_DECS]; // RL8
				lim = rw[ailc_pkg::S_DECM][6:0]; // RL8
			end
		end

		// peak of the tick, held as running max or latest sample
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				pk <= '0;
			else if (take)
				pk <= (cfg[ailc_pkg::CFG_VMAX] && pk > ax) ? pk : ax; // RL5
			else if (tick && cfg[ailc_pkg::CFG_TCLR])
				pk <= '0; // RL5
		end

		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				lvl <= '0;
			else if (tick)
				lvl <= iir ? mix[23:8] : pk; // RL5
		end

		always_ff @(posedge clk_i)
		begin
			if (rst_i || step)
				sc <= '0;
			else
				sc <= sc + 8'h01;
		end

		always_ff @(posedge clk_i)
		begin
			if (rst_i || tick)
				used <= '0; // RL7
			else if (chg[c] && am)
				used <= used + 7'h01;
		end

		// gain moves one code per pace step, but in auto mode jumps straight to maxl when above it, or to minl when below it and minl <= maxl
		always_ff @(posedge clk_i)
		begin
			chg[c] <= 1'b0;
			if (rst_i)
				g <= '0;
			else if (am && g > maxl)
				g <= maxl; // RL17
			else if (am && g < minl && minl <= maxl)
				g <= minl; // RL18
			else if (step && am && cfg[ailc_pkg::CFG_ANA])
			begin
				if ((noise || hi) && g > minl && used < lim)
				begin
					g <= g - 7'h01; // RL8 RL9 RL18 RL19
					chg[c] <= 1'b1;
				end
				else if (!noise && lo && g < maxl && used < lim)
				begin
					g <= g + 7'h01; // RL7 RL18 RL19
					chg[c] <= 1'b1;
				end
			end
			else if (step && !am && g != tgt[6:0])
			begin
				g <= (g < tgt[6:0]) ? g + 7'h01 : g - 7'h01; // RL11
				chg[c] <= 1'b1;
			end
		end

		always_ff @(posedge clk_i)
		begin
			if (rst_i)
				mcnt <= '0;
			else if (chg[c] && am)
				mcnt <= rw[ailc_pkg::S_MASK][3:0]; // RL6
			else if (take && mcnt != 4'h0)
				mcnt <= mcnt - 4'h1;
		end

		property p_gmax;
			@(posedge clk_i) disable iff (rst_i)
			am && $stable(vol) && $stable(maxl) ##1 am && $stable(maxl)
				|-> g <= maxl;
		endproperty
		a_gmax: assert property (p_gmax) // RL17
			else $error("auto gain above maximum");

		property p_budget;
			@(posedge clk_i) disable iff (rst_i)
			am && chg[c] |-> $past(used) < $past(lim);
		endproperty
		a_budget: assert property (p_budget) // RL7
			else $error("gain step past tick budget");

		property p_mask;
			@(posedge clk_i) disable iff (rst_i)
			chg[c] && am && !tick |=> mcnt == $past(rw[ailc_pkg::S_MASK][3:0]);
		endproperty
		a_mask: assert property (p_mask) // RL6
			else $error("mask count not loaded");

		property p_fall;
			@(posedge clk_i) disable iff (rst_i)
			chg[c] && am && (g < $past(g)) |-> $past(noise || hi);
		endproperty
		a_fall: assert property (p_fall) // RL8
			else $error("gain fell without cause");
	end

	// ************************************************************
	// amplifier outputs
	// ************************************************************
	wire [7:0] fix = rw[ailc_pkg::S_FIX];
	wire       swp = rw[ailc_pkg::S_SWAP][0];
	wire [6:0] gl = fix[ailc_pkg::TOP_BIT] ? fix[6:0] : gain[0]; // RL14
	wire [6:0] gr = fix[ailc_pkg::TOP_BIT] ? fix[6:0] : gain[1]; // RL14

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			amp_gain_o <= '0;
			amp_mute_o <= 2'h0;
		end
		else
		begin
			amp_gain_o.l <= swp ? gr : gl; // RL15
			amp_gain_o.r <= swp ? gl : gr; // RL15
			amp_mute_o <= swp ? {mute[0], mute[1]} : mute; // RL15
		end
	end

	sequence s_fix_held;
		fix[ailc_pkg::TOP_BIT] ##1 fix[ailc_pkg::TOP_BIT] && $stable(fix);
	endsequence

	property p_fix;
		@(posedge clk_i) disable iff (rst_i)
		s_fix_held |=> amp_gain_o.l == $past(fix[6:0])
			&& amp_gain_o.r == $past(fix[6:0]);
	endproperty
	a_fix: assert property (p_fix) // RL14
		else $error("fixed gain not applied");

	property p_swap;
		@(posedge clk_i) disable iff (rst_i)
		swp && !fix[ailc_pkg::TOP_BIT] |=> amp_gain_o.l == $past(gain[1]);
	endproperty
	a_swap: assert property (p_swap) // RL15
		else $error("channels not swapped");

	sequence s_mute_wr;
		wr && adr == ailc_pkg::IDX_VALL;
	endsequence

	property p_mute;
		@(posedge clk_i) disable iff (rst_i)
		s_mute_wr ##0 !swp ##1 !wr [*1] |=> amp_mute_o[0] == $past(dat_i[7], 2);
	endproperty
	a_mute: assert property (p_mute) // RL13
		else $error("mute write lost");

	property p_tick;
		@(posedge clk_i) disable iff (rst_i)
		tick |=> tcnt == 16'h0000 ##[1:2] !tick || period <= 16'h0002;
	endproperty
	a_tick: assert property (p_tick) // RL4
		else $error("tick counter not restarted");
endmodule
`default_nettype wire

// file: test/ailc_src_model.sv
// sample source that stands in for the analog amplifier and adc.
// assumes the block's input handshake: a word is taken when valid
// and ready meet at a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ailc_src_model
(
	input  wire logic          clk_i,   // clock
	input  wire logic          rst_i,   // sync reset
	input  wire logic          en_i,    // produce samples
	input  wire logic [15:0]   lvl_i,   // left channel amplitude
	input  wire logic          ready_i, // block accepts
	output ailc_pkg::ailc_smp_t smp_o,  // sample word
	output logic               valid_o, // sample valid
	output logic [15:0]        sent_o   // words accepted so far
);
	logic        take;
	logic [15:0] next_seq;

	assign take = valid_o && ready_i;
	assign next_seq = sent_o + {15'h0, take};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			valid_o <= 1'b0;
			sent_o  <= 16'h0;
			smp_o   <= '0;
		end
		else
		begin
			if (take)
				sent_o <= next_seq;
			// a pending word is held until taken; idle data keeps toggling
			if (!valid_o || ready_i)
			begin
				valid_o <= en_i;
				smp_o   <= en_i ? {lvl_i, next_seq} : ~smp_o;
			end
		end
	end
endmodule
`default_nettype wire

// file: test/tb.sv
// register and sample-path testbench of the level control block.
// assumes one byte per wishbone word and a one-cycle ack.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                clk_i;
	logic                rst_i;
	logic                cyc;
	logic                stb;
	logic                we;
	logic [11:0]         adr;
	logic [31:0]         wdat;
	logic [31:0]         dat_o;
	logic                ack_o;
	logic [31:0]         rdat;
	ailc_pkg::ailc_smp_t in_i;
	ailc_pkg::ailc_smp_t out_o;
	ailc_pkg::ailc_gain_t amp_gain_o;
	logic [1:0]          amp_mute_o;
	logic                in_valid_i;
	logic                in_ready_o;
	logic                out_valid_o;
	logic                out_ready_i;
	logic                src_en;
	logic [15:0]         lvl;
	logic [15:0]         sent;
	int                  n_mismatch;
	int                  total_checks;
	int                  rcv;
	bit                  ord_on;
	bit                  mask_on;
	bit                  saw_zero;
	logic [15:0]         lvls [4] = '{16'h0010, 16'h4000, 16'h0010, 16'h0000};
	logic [6:0]          gexp [4] = '{7'h08, 7'h02, 7'h08, 7'h02};

	ailc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .dat_i(wdat), .sel_i(4'h1), .dat_o(dat_o),
		.ack_o(ack_o), .in_i(in_i), .in_valid_i(in_valid_i),
		.in_ready_o(in_ready_o), .out_o(out_o), .out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i), .amp_gain_o(amp_gain_o),
		.amp_mute_o(amp_mute_o));

	ailc_src_model u_src (.clk_i(clk_i), .rst_i(rst_i), .en_i(src_en),
		.lvl_i(lvl), .ready_i(in_ready_o), .smp_o(in_i),
		.valid_o(in_valid_i), .sent_o(sent));

	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic timeout();
		n_mismatch++;
		$display("Error %0t: wait ran out", $time);
		end_sim();
	endtask

	// one classic cycle; read data is taken at the edge that sees ack
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= {24'h0, d};
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		// judge by the answer itself, so an ack on the last of the 20 waits is not a timeout
		if (ack_o !== 1'b1)
			timeout();
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		acc(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		acc(1'b0, a, 8'h00);
		chk(rdat, {24'h0, exp});
	endtask

	task automatic wait_gain(input logic [6:0] g);
		int n;
		for (n = 0; n < 3000 && amp_gain_o.l !== g; n++)
			@(posedge clk_i);
		if (n >= 3000)
			timeout();
	endtask

	always @(posedge clk_i)
	begin
		if (out_valid_o === 1'b1 && out_ready_i)
		begin
			if (ord_on)
				chk(32'(out_o), {lvl, rcv[15:0]});
			if (mask_on && out_o.l === 16'h0)
				saw_zero = 1'b1;
			rcv++;
		end
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	initial
	begin
		int n;
		logic [7:0] e;
		rst_i <= 1'b1;
		{cyc, stb, we, src_en, out_ready_i} <= '0;
		{adr, wdat, lvl} <= '0;
		{n_mismatch, total_checks, rcv} = '0;
		{ord_on, mask_on, saw_zero} = '0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		for (n = 0; n < ailc_pkg::NRW; n++)
		begin
			// gain and manual target both start at 0, so done reads set
			e = ailc_pkg::RW_RST[n];
			if (n == ailc_pkg::S_TGTL || n == ailc_pkg::S_TGTR)
				e[7] = 1'b1;
			rd(ailc_pkg::RW_IDX[n], e);
		end
		wr(ailc_pkg::IDX_AMPL, 8'h55);
		rd(ailc_pkg::IDX_AMPL, 8'h00);
		wr(12'hb45, 8'h77);
		rd(12'hb45, 8'h00);
		wr(12'hb63, 8'ha5);
		repeat (3) @(posedge clk_i);
		chk(32'(amp_gain_o), 32'({7'h25, 7'h25}));
		wr(12'hb63, 8'h25);
		repeat (3) @(posedge clk_i);
		chk(32'(amp_gain_o), 32'h0);
		wr(ailc_pkg::IDX_VALL, 8'h80);
		rd(ailc_pkg::IDX_VALL, 8'h80);
		chk(32'(amp_mute_o), 32'h1);
		wr(12'hb64, 8'h01);
		repeat (3) @(posedge clk_i);
		chk(32'(amp_mute_o), 32'h2);
		wr(12'hb64, 8'h00);
		wr(ailc_pkg::IDX_VALL, 8'h00);
		// quick judge pace: one step every five cycles
		wr(12'hb60, 8'h04);
		wr(12'hb61, 8'h05);
		repeat (60) @(posedge clk_i);
		rd(12'hb61, 8'h85);
		rd(ailc_pkg::IDX_VALL, 8'h05);
		rd(ailc_pkg::IDX_CURL, 8'h20);
		chk(32'(amp_gain_o), 32'({7'h05, 7'h00}));
		wr(12'hb64, 8'h01);
		repeat (3) @(posedge clk_i);
		chk(32'(amp_gain_o), 32'({7'h00, 7'h05}));
		wr(12'hb64, 8'h00);
		// fill the buffer with the far side stalled, then drain it
		lvl    <= 16'h0010;
		src_en <= 1'b1;
		ord_on = 1'b1;
		for (n = 0; n < 100 && in_ready_o !== 1'b0; n++)
			@(posedge clk_i);
		if (n >= 100)
			timeout();
		src_en <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(32'(in_ready_o), 32'h0);
		out_ready_i <= 1'b1;
		for (n = 0; n < 200 && (in_valid_i || rcv != 32'(sent)); n++)
			@(posedge clk_i);
		if (n >= 200)
			timeout();
		chk(32'(rcv >= ailc_pkg::FIFO_DEPTH), 32'h1);
		ord_on = 1'b0;
		// auto mode, short tick, limits 2..8, no smoothing
		wr(12'hb43, 8'h08);
		wr(12'hb50, 8'h10);
		wr(12'hb51, 8'h00);
		wr(12'hb54, 8'h01);
		wr(12'hb56, 8'h04);
		wr(12'hb41, 8'h82);
		src_en <= 1'b1;
		for (n = 0; n < 4; n++)
		begin
			lvl <= lvls[n];
			mask_on = (n == 0);
			wait_gain(gexp[n]);
			repeat (200) @(posedge clk_i);
			chk(32'(amp_gain_o.l), 32'(gexp[n]));
		end
		chk(32'(saw_zero), 32'h1);
		rd(ailc_pkg::IDX_CURL, 8'h02);
		rd(ailc_pkg::IDX_AMPL, 8'h02);
		rd(ailc_pkg::IDX_AMPR, 8'h00);
		end_sim();
	end
endmodule
`default_nettype wire
